// [dtps_consts.vh]
// constants for the drive test parameter sequencer
// assumes a single 100 MHz clock and active-low asynchronous reset
// Functional notes
// [RULE1] error override keeps the operation running
// [RULE2] override counts read errors in status 94
// [RULE3] override logs other errors when bit 2
// [RULE4] option bit 4 picks random head
// [RULE5] option bit 5 picks random record
// [RULE6] bit 6 clears head, increments per op
// [RULE7] bit 7 uses record register 83
// [RULE8] sequential seeks step by increment 81
// [RULE9] no increment entered means stride one
// [RULE10] increment bit 15 halves reverse cylinder
// [RULE11] parameter 82 tag/bus driven to drive
// [RULE12] no control bits: tag repeats until go
// [RULE13] bit 11 holds tag until go
// [RULE14] bit 15 bypasses tag gate error
// [RULE15] single-step issues tag once per press
// [RULE16] hold, bypass, single-step combine freely
// [RULE17] log-error bit counts function errors in fault log
// [RULE18] head register gives fixed head otherwise
// [RULE19] parameters are 16-bit operator words; the option word keeps only bits 7:0, upper byte forced to zero
`ifndef DTPS_CONSTS_VH
`define DTPS_CONSTS_VH
`define DTPS_PAR_OPTION      4'h0
`define DTPS_PAR_SEEK_INC    4'h1
`define DTPS_PAR_MAN_TAG     4'h2
`define DTPS_PAR_RECORD      4'h3
`define DTPS_PAR_HEAD        4'h5
`define DTPS_OPT_SINGLE      1
`define DTPS_OPT_LOG_ERROR   2
`define DTPS_OPT_ERR_OVR     3
`define DTPS_OPT_RAND_HEAD   4
`define DTPS_OPT_RAND_REC    5
`define DTPS_OPT_SEQ_HEAD    6
`define DTPS_OPT_MAN_REC     7
`define DTPS_INC_SHIFT       15
`define DTPS_TAG_HOLD        11
`define DTPS_TAG_BYPASS      15
`define DTPS_TAG_FIELD_MSB   10
`define DTPS_RESET_WORD      16'h0000
`define DTPS_LFSR_SEED       16'hACE1
`define DTPS_STRIDE_ONE      16'h0001
`endif

// [dtps_drive_model.sv]
// drive side of the manual tag: acknowledges a raised tag after a delay
// assumes the sequencer's clock and reset
`timescale 1ns/1ps
module dtps_drive_model #(
  parameter int DLY = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tag_valid,
  output logic      tag_ack
);
  logic [3:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 4'h0;
      tag_ack <= 1'b0;
    end else begin
      tag_ack <= tag_valid && cnt == 4'(DLY);
      cnt     <= (!tag_valid || cnt == 4'(DLY)) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule // dtps_drive_model

// [dtps_props.sv]
// checker for the sequencer's counters, logs, stop and seek stepping
// assumes it is bound to dtps_sequencer with one clock domain
`timescale 1ns/1ps
module dtps_props (
  input wire        clk,
  input wire        rst_n,
  input wire        op_done,
  input wire        read_error,
  input wire        other_error,
  input wire        test_function_error,
  input wire        running,
  input wire [15:0] cylinder,
  input wire [15:0] read_err_count,
  input wire        error_log_wr,
  input wire        fault_log_wr,
  input wire [15:0] fault_count,
  input wire        stopped_on_error
);
  // ==========
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RD_STEP: assert property ($changed(read_err_count) |->
    read_err_count == $past(read_err_count) + 16'h0001) else $error("read count step");
  AST_RD_CAUSE: assert property ($changed(read_err_count) |-> $past(read_error))
    else $error("read count cause");
  AST_FC_STEP: assert property ($changed(fault_count) |->
    fault_count == $past(fault_count) + 16'h0001) else $error("fault count step");
  AST_FC_CAUSE: assert property ($changed(fault_count) |-> $past(test_function_error))
    else $error("fault count cause");
  AST_FLT_ALSO: assert property (fault_log_wr |-> error_log_wr) else $error("flt");
  AST_ELOG: assert property (error_log_wr |-> $past(other_error) ||
    $past(test_function_error)) else $error("error log cause");
  AST_STOP: assert property ($rose(stopped_on_error) |-> $fell(running)) else $error("stop");
  AST_CYL: assert property ($changed(cylinder) |-> $past(op_done)) else $error("cyl");
  cover property ($rose(running));
  cover property (fault_log_wr);
  cover property ($rose(stopped_on_error));
endmodule // dtps_props
bind dtps_sequencer dtps_props u_props (.clk, .rst_n, .op_done, .read_error, .other_error,
  .test_function_error, .running, .cylinder, .read_err_count, .error_log_wr,
  .fault_log_wr, .fault_count, .stopped_on_error);

// [dtps_sequencer.v]
// drive test parameter sequencer: options, seek stepping, manual tag issue
// assumes operator entries and drive status are synchronous to clk
`timescale 1ns/1ps
`include "dtps_consts.vh"
module dtps_sequencer (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        param_wr,
  input  wire [3:0]  param_sel,
  input  wire [15:0] param_data,
  input  wire        operator_go_switch,
  input  wire        seq_reverse,
  input  wire        op_done,
  input  wire        read_error,
  input  wire        other_error,
  input  wire        test_function_error,
  input  wire        tag_gate_error,
  input  wire        tag_ack,
  output reg         running,
  output reg  [15:0] cylinder,
  output reg  [15:0] head,
  output reg  [15:0] record,
  output reg         tag_valid,
  output reg  [10:0] tag_bus,
  output reg  [15:0] read_err_count,
  output reg         error_log_wr,
  output reg         fault_log_wr,
  output reg  [15:0] fault_count,
  output reg         stopped_on_error
);
  // ==========================================================
  // parameter words
  reg [15:0] opt_word;
  reg [15:0] seek_inc;
  reg        inc_entered;
  reg [15:0] man_tag;
  reg [15:0] rec_reg;
  reg [15:0] head_reg;
  reg [15:0] lfsr;
  reg        go_q;
  reg        tag_mode;
  wire       go_press = operator_go_switch & ~go_q;
  wire       ovr      = opt_word[`DTPS_OPT_ERR_OVR];
  wire       log_en   = opt_word[`DTPS_OPT_LOG_ERROR];
  wire       single   = opt_word[`DTPS_OPT_SINGLE];
  wire [15:0] stride  = inc_entered ? {1'b0, seek_inc[14:0]} : `DTPS_STRIDE_ONE; // RULE8 RULE9
  wire       any_err  = read_error | other_error | test_function_error;
  wire       tag_err  = tag_gate_error & ~man_tag[`DTPS_TAG_BYPASS]; // RULE14
  wire [15:0] next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};

  // ==========================================================
  // operator entry
  reg  [15:0] next_opt_word;
  reg  [15:0] next_seek_inc;
  reg         next_inc_entered;
  reg  [15:0] next_man_tag;
  reg  [15:0] next_rec_reg;

  always @* begin
    next_opt_word    = opt_word;
    next_seek_inc    = seek_inc;
    next_inc_entered = inc_entered;
    next_man_tag     = man_tag;
    next_rec_reg     = rec_reg;
    if (param_wr) begin // RULE19
      case (param_sel)
        `DTPS_PAR_OPTION: next_opt_word = {8'h00, param_data[7:0]};
        `DTPS_PAR_SEEK_INC: begin
          next_seek_inc    = param_data;
          // a zero stride counts as no entry
          next_inc_entered = (param_data[14:0] != 15'h0000); // RULE9
        end
        `DTPS_PAR_MAN_TAG: next_man_tag = param_data; // RULE11
        `DTPS_PAR_RECORD:  next_rec_reg = param_data;
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_word    <= `DTPS_RESET_WORD;
      seek_inc    <= `DTPS_RESET_WORD;
      inc_entered <= 1'b0;
      man_tag     <= `DTPS_RESET_WORD;
      rec_reg     <= `DTPS_RESET_WORD;
    end else begin
      opt_word    <= next_opt_word;
      seek_inc    <= next_seek_inc;
      inc_entered <= next_inc_entered;
      man_tag     <= next_man_tag;
      rec_reg     <= next_rec_reg;
    end
  end

  // ==========================================================
  // go edge detect and pseudo-random source
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
      lfsr <= `DTPS_LFSR_SEED;
    end else begin
      go_q <= operator_go_switch;
      lfsr <= next_lfsr;
    end
  end

  // ==========================================================
  // shared step logic for the counters and the head register
  wire        op_taken     = running & ~go_press & op_done;
  wire        err_window   = running & ~go_press;
  wire        rd_cnt_step  = err_window & ovr & read_error; // RULE2
  wire        flt_cnt_step = err_window & test_function_error & log_en; // RULE17
  wire        head_step    = op_taken & opt_word[`DTPS_OPT_SEQ_HEAD]; // RULE6
  wire [15:0] rd_cnt_plus;
  wire [15:0] flt_cnt_plus;
  wire [15:0] head_plus;

  dtps_incr #(
    .W (16)
  ) u_rd_cnt (
    .value  (read_err_count),
    .step   (rd_cnt_step),
    .result (rd_cnt_plus)
  );

  dtps_incr #(
    .W (16)
  ) u_flt_cnt (
    .value  (fault_count),
    .step   (flt_cnt_step),
    .result (flt_cnt_plus)
  );

  dtps_incr #(
    .W (16)
  ) u_head_cnt (
    .value  (head_reg),
    .step   (head_step),
    .result (head_plus)
  );

  // ==========================================================
  // run control and error handling
  reg         next_running;
  reg         next_stopped;
  reg         next_error_log_wr;
  reg         next_fault_log_wr;

  always @* begin
    next_running      = running;
    next_stopped      = stopped_on_error;
    next_error_log_wr = 1'b0;
    next_fault_log_wr = 1'b0;
    if (go_press) begin
      next_running = ~running;
      next_stopped = 1'b0;
    end else if (running) begin
      if (test_function_error) begin
        // function errors reach the error log whatever bit 2 says
        next_error_log_wr = 1'b1; // RULE17
        next_fault_log_wr = log_en; // RULE17
      end
      if (ovr) begin
        if (other_error && log_en)
          next_error_log_wr = 1'b1; // RULE3
      end else if (any_err || tag_err) begin
        // without override any error ends the test
        next_running = 1'b0; // RULE1
        next_stopped = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running          <= 1'b0;
      stopped_on_error <= 1'b0;
      error_log_wr     <= 1'b0;
      fault_log_wr     <= 1'b0;
    end else begin
      running          <= next_running;
      stopped_on_error <= next_stopped;
      error_log_wr     <= next_error_log_wr;
      fault_log_wr     <= next_fault_log_wr;
    end
  end

  // ==========================================================
  // status counters
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_err_count <= `DTPS_RESET_WORD;
      fault_count    <= `DTPS_RESET_WORD;
    end else begin
      read_err_count <= rd_cnt_plus; // RULE2
      fault_count    <= flt_cnt_plus; // RULE17
    end
  end

  // ==========================================================
  // head register, head and record selection
  reg  [15:0] next_head_reg;
  reg  [15:0] next_head;
  reg  [15:0] next_record;

  always @* begin
    next_head_reg = head_reg;
    if (param_wr && param_sel == `DTPS_PAR_HEAD)
      next_head_reg = param_data; // RULE18
    if (go_press && !running && opt_word[`DTPS_OPT_SEQ_HEAD])
      next_head_reg = `DTPS_RESET_WORD; // RULE6
    else if (head_step)
      next_head_reg = head_plus; // RULE6
  end

  always @* begin
    next_head   = head;
    next_record = record;
    if (op_taken) begin
      if (opt_word[`DTPS_OPT_RAND_HEAD])
        next_head = {8'h00, lfsr[7:0]}; // RULE4
      else
        next_head = head_reg; // RULE18
      if (opt_word[`DTPS_OPT_MAN_REC])
        next_record = rec_reg; // RULE7
      else if (opt_word[`DTPS_OPT_RAND_REC])
        next_record = {8'h00, lfsr[15:8]}; // RULE5
    end
  end

  // ==========================================================
  // cylinder stepping for sequential seeks
  reg  [15:0] next_cylinder;

  always @* begin
    next_cylinder = cylinder;
    if (op_taken) begin
      if (seq_reverse && seek_inc[`DTPS_INC_SHIFT])
        // shift-bit reverse ignores the stride
        next_cylinder = {1'b0, cylinder[15:1]}; // RULE10
      else if (seq_reverse)
        next_cylinder = cylinder - stride; // RULE8
      else
        next_cylinder = cylinder + stride; // RULE8 RULE9
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= `DTPS_RESET_WORD;
      head     <= `DTPS_RESET_WORD;
      record   <= `DTPS_RESET_WORD;
      cylinder <= `DTPS_RESET_WORD;
    end else begin
      head_reg <= next_head_reg;
      head     <= next_head;
      record   <= next_record;
      cylinder <= next_cylinder;
    end
  end

  // ==========================================================
  // manual tag issue: repeat, hold or single shot
  reg         next_tag_valid;
  reg         next_tag_mode;

  always @* begin
    next_tag_valid = tag_valid;
    next_tag_mode  = tag_mode;
    if (single) begin
      // one tag per press; hold keeps it through a tag gate error
      next_tag_mode = 1'b0;
      if (go_press)
        next_tag_valid = 1'b1; // RULE15 RULE16
      else if (tag_ack || (tag_err && !man_tag[`DTPS_TAG_HOLD]))
        next_tag_valid = 1'b0;
    end else begin
      if (go_press)
        next_tag_mode = ~tag_mode;
      if (!tag_mode || (tag_err && !ovr))
        next_tag_valid = 1'b0;
      else if (man_tag[`DTPS_TAG_HOLD])
        next_tag_valid = 1'b1; // RULE13 RULE16
      else
        next_tag_valid = ~tag_valid | ~tag_ack; // RULE12 RULE14
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_valid <= 1'b0;
      tag_bus   <= 11'h000;
      tag_mode  <= 1'b0;
    end else begin
      tag_valid <= next_tag_valid;
      tag_bus   <= man_tag[`DTPS_TAG_FIELD_MSB:0]; // RULE11
      tag_mode  <= next_tag_mode;
    end
  end
endmodule // dtps_sequencer

// ==========================================================
// incrementer shared by the counters and the head register
module dtps_incr #(
  parameter W = 16
) (
  input  wire [W-1:0] value,
  input  wire         step,
  output wire [W-1:0] result
);
  assign result = step ? value + {{(W-1){1'b0}}, 1'b1} : value;
endmodule // dtps_incr

// [dtps_sequencer_tb.sv]
// testbench: parameter entry, go presses, op and error pulses
// assumes dtps_props is bound and the drive model answers tags
`timescale 1ns/1ps
`include "dtps_consts.vh"
module dtps_sequencer_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rev = 1'b0, ack;
  logic [3:0]  sel = 4'h0;
  logic [15:0] dat = 16'h0000, cyl, hd, rec, rdc, fc;
  logic [5:0]  pl = 6'h00;
  logic [10:0] tb_bus;
  logic        run, tv, stp;
  int          fails = 0, n_checks = 0;
  logic        elw, flw;
  logic [15:0] hd_a, rec_a;
  int          n_elog = 0, n_flog = 0, n_ack = 0, a0 = 0;
  // counts one-cycle pulses while they stand
  always @(posedge clk) begin
    if (elw) n_elog++;
    if (flw) n_flog++;
    if (ack) n_ack++;
  end
  always #5 clk = ~clk;
  dtps_sequencer uut (.clk(clk), .rst_n(rst_n), .param_wr(wr), .param_sel(sel),
    .param_data(dat), .operator_go_switch(pl[5]), .seq_reverse(rev), .op_done(pl[0]),
    .read_error(pl[1]), .other_error(pl[2]), .test_function_error(pl[3]),
    .tag_gate_error(pl[4]), .tag_ack(ack), .running(run), .cylinder(cyl), .head(hd),
    .record(rec), .tag_valid(tv), .tag_bus(tb_bus), .read_err_count(rdc),
    .error_log_wr(elw), .fault_log_wr(flw), .fault_count(fc), .stopped_on_error(stp));
  dtps_drive_model drv (.clk(clk), .rst_n(rst_n), .tag_valid(tv), .tag_ack(ack));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wp(input logic [3:0] s, input logic [15:0] d);
    @(posedge clk);
    {wr, sel, dat} <= {1'b1, s, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // pl bits: 0 op, 1 read, 2 other, 3 function, 4 tag gate, 5 go
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    pl <= m;
    @(posedge clk);
    pl <= 6'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst;
    wp(`DTPS_PAR_SEEK_INC, 16'h0003);
    pulse(6'h20);
    pulse(6'h01);
    pulse(6'h01);
    chk("cylinder", 16'h0006, cyl);
    wp(`DTPS_PAR_SEEK_INC, 16'h0000);
    pulse(6'h01);
    chk("cylinder", 16'h0007, cyl);
    @(posedge clk);
    rev <= 1'b1;
    wp(`DTPS_PAR_SEEK_INC, 16'h8000);
    pulse(6'h01);
    chk("cylinder", 16'h0003, cyl);
    wp(`DTPS_PAR_HEAD, 16'h0004);
    wp(`DTPS_PAR_RECORD, 16'h0055);
    wp(`DTPS_PAR_OPTION, 16'h0080);
    pulse(6'h01);
    chk("head", 16'h0004, hd);
    chk("record", 16'h0055, rec);
    wp(`DTPS_PAR_OPTION, 16'h000C);
    pulse(6'h02);
    pulse(6'h08);
    pulse(6'h04);
    chk("read_err_count", 16'h0001, rdc);
    chk("fault_count", 16'h0001, fc);
    chk("running", 16'h0001, {15'h0, run});
    chk("error_log_wr count", 16'h0002, 16'(n_elog));
    chk("fault_log_wr count", 16'h0001, 16'(n_flog));
    wp(`DTPS_PAR_OPTION, 16'h0008);
    pulse(6'h04);
    chk("error_log_wr count", 16'h0002, 16'(n_elog));
    wp(`DTPS_PAR_OPTION, 16'h0040);
    pulse(6'h20);
    pulse(6'h20);
    pulse(6'h01);
    pulse(6'h01);
    chk("head", 16'h0001, hd);
    wp(`DTPS_PAR_OPTION, 16'h0030);
    pulse(6'h01);
    hd_a = hd;
    rec_a = rec;
    pulse(6'h01);
    chk("head changes", 16'h0001, {15'h0, hd != hd_a});
    chk("head high byte", 16'h0000, {8'h00, hd[15:8]});
    chk("record changes", 16'h0001, {15'h0, rec != rec_a});
    wp(`DTPS_PAR_OPTION, 16'h0000);
    pulse(6'h02);
    chk("running", 16'h0000, {15'h0, run});
    chk("stopped", 16'h0001, {15'h0, stp});
    rst;
    wp(`DTPS_PAR_MAN_TAG, 16'h0A5A);
    pulse(6'h20);
    repeat (6) @(posedge clk);
    #1;
    chk("tag_valid", 16'h0001, {15'h0, tv});
    chk("tag_bus", 16'h025A, {5'h0, tb_bus});
    wp(`DTPS_PAR_MAN_TAG, 16'h825A);
    pulse(6'h10);
    chk("running", 16'h0001, {15'h0, run});
    a0 = n_ack;
    repeat (20) @(posedge clk);
    #1;
    chk("tag repeats", 16'h0001, {15'h0, (n_ack - a0) >= 3});
    wp(`DTPS_PAR_OPTION, 16'h0002);
    repeat (10) @(posedge clk);
    #1;
    a0 = n_ack;
    pulse(6'h20);
    repeat (20) @(posedge clk);
    #1;
    chk("single tags", 16'h0001, 16'(n_ack - a0));
    chk("tag_valid", 16'h0000, {15'h0, tv});
    stop_test;
  end
endmodule // dtps_sequencer_tb
